// [common/upr_consts.svh]
`ifndef UPR_CONSTS_SVH
`define UPR_CONSTS_SVH

// Register addresses in the special function space
`define UPR_LOW_DATA_ADDR   8'h90
`define UPR_LOW_DIR_ADDR    8'h91
`define UPR_HIGH_DATA_ADDR  8'hA0
`define UPR_HIGH_DIR_ADDR   8'hA1

// Route select registers in the external data space, four in a row
`define UPR_ROUTE_BASE_ADDR 16'hFF90
`define UPR_ROUTE_COUNT     4

// Upper address byte of every special function register
`define UPR_SFR_PAGE        8'h00

// Reset values
`define UPR_DIR_RESET       8'hFF
`define UPR_DATA_RESET      8'hFF
`define UPR_ROUTE_RESET     8'h00
`define UPR_PIN_RESET       9'h1FF
`define UPR_OE_RESET        9'h000

// Field layout of a route select register, and the mask of pin 8's direction register
`define UPR_SEL_W           3
`define UPR_EVEN_LSB        0
`define UPR_ODD_LSB         4
`define UPR_ROUTE_MASK      8'h77
`define UPR_HIGH_MASK       8'h01

// Resource select codes
`define UPR_SEL_TIMER0      3'h2
`define UPR_SEL_TIMER1      3'h3
`define UPR_SEL_IRQ0_HIGH   3'h4
`define UPR_SEL_IRQ1_HIGH   3'h5
`define UPR_SEL_IRQ0_LOW    3'h6
`define UPR_SEL_IRQ1_LOW    3'h7

// Pin counts
`define UPR_LOW_PINS        8
`define UPR_ALL_PINS        9

`endif

// [common/upr_pkg.sv]
`default_nettype none

package upr_pkg;

  // One CPU access to the block's registers
  typedef struct packed {
    logic        xram;
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
  } upr_bus_req_t;

  // Internal resource signals fed from the pins
  typedef struct packed {
    logic timer_zero_gate_clock;
    logic timer_one_gate_clock;
    logic irq_zero_request;
    logic irq_one_request;
  } upr_route_t;

endpackage

`default_nettype wire

// [src/upr_user_pin_port_router.sv]
// How it works
// R1: Nine user pins, 0 to 8, each with its own direction bit.
// R2: After reset pins are pulled-up inputs until their group's direction register is written.
// R3: Direction bit 0 makes the pin an output, 1 makes it an input.
// R4: Pins 0-7 sit in data register bits 7:0, pin 8 in bit 0 of another.
// R5: Each of pins 0-7 has a 3-bit select field, two per control register.
// R6: Codes 0,1 route nowhere; 2 drives timer 0 input, 3 timer 1 input.
// R7: Codes 4,5 feed irq 0/1 active high; 6,7 feed irq 0/1 active low.
// R8: Several pins on one resource are combined by logical OR.
// R9: The timer control type bit picks edge or level for each pin interrupt.
// R10: Four select registers from 0xFF90, reset to zero, fields at bits 2:0 and 6:4.
// R11: Pin inputs pass two flip-flops before registers or routing see them.
`timescale 1ns/10ps
`include "upr_consts.svh"
`default_nettype none

module upr_user_pin_port_router
  import upr_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  input  wire upr_bus_req_t bus_req,
  output var  logic [7:0]   bus_rdata_ff,
  output var  logic         bus_rvalid_ff,
  input  wire logic [8:0]   user_pin_in,
  output var  logic [8:0]   user_pin_out_ff,
  output var  logic [8:0]   user_pin_oe_ff,
  output var  logic [8:0]   user_pin_pullup_ff,
  input  wire logic         irq_zero_type,
  input  wire logic         irq_one_type,
  output var  upr_route_t   route_out_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Pick the select field of one pin out of its control register
  function automatic logic [2:0] pin_field(input logic [7:0] ctrl, input logic odd);
    pin_field = odd ? ctrl[`UPR_ODD_LSB +: `UPR_SEL_W] : ctrl[`UPR_EVEN_LSB +: `UPR_SEL_W];
  endfunction

  // Pins among 0 to 7 whose select field holds one resource code
  function automatic logic [7:0] sel_hits(input logic [23:0] sels, input logic [2:0] code);
    sel_hits = 8'h00;
    for (int p = 0; p < `UPR_LOW_PINS; p++)
      sel_hits[p] = (sels[p * `UPR_SEL_W +: `UPR_SEL_W] == code);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [8:0] sync1_ff;
  logic [8:0] sync2_ff;
  logic [7:0] low_group_direction_ff;
  logic [7:0] high_pin_direction_ff;
  logic [7:0] low_group_data_ff;
  logic [7:0] high_pin_data_ff;
  logic [7:0] route_ctrl_ff [0:`UPR_ROUTE_COUNT-1];
  logic       low_pullup_ff;
  logic       high_pullup_ff;
  logic       irq_zero_lvl_ff;
  logic       irq_one_lvl_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  wire logic       sfr_acc       = ~bus_req.xram & (bus_req.addr[15:8] == `UPR_SFR_PAGE);
  wire logic       hit_low_data  = sfr_acc & (bus_req.addr[7:0] == `UPR_LOW_DATA_ADDR);
  wire logic       hit_low_dir   = sfr_acc & (bus_req.addr[7:0] == `UPR_LOW_DIR_ADDR);
  wire logic       hit_high_data = sfr_acc & (bus_req.addr[7:0] == `UPR_HIGH_DATA_ADDR);
  wire logic       hit_high_dir  = sfr_acc & (bus_req.addr[7:0] == `UPR_HIGH_DIR_ADDR);
  wire logic [15:0] route_off    = bus_req.addr - `UPR_ROUTE_BASE_ADDR;
  wire logic       hit_route     = bus_req.xram & (route_off < 16'(`UPR_ROUTE_COUNT)); // R10
  wire logic [1:0] route_idx     = route_off[1:0];

  // Write strobes, one per register kind
  wire logic       wr_low_data   = bus_req.wr & hit_low_data;
  wire logic       wr_low_dir    = bus_req.wr & hit_low_dir;
  wire logic       wr_high_data  = bus_req.wr & hit_high_data;
  wire logic       wr_high_dir   = bus_req.wr & hit_high_dir;
  wire logic       wr_route      = bus_req.wr & hit_route;

  // Pin values as software sees them: pin level for inputs, latch for outputs
  wire logic [7:0] low_view  = (sync2_ff[7:0] & low_group_direction_ff)
                             | (low_group_data_ff & ~low_group_direction_ff); // R4
  wire logic       high_view = high_pin_direction_ff[0] ? sync2_ff[8] : high_pin_data_ff[0]; // R4

  // Read data mux, unmapped addresses read zero
  logic [7:0] nxt_rdata;
  always_comb
  begin
    nxt_rdata = 8'h00;
    if (hit_low_data)
      nxt_rdata = low_view;
    else if (hit_low_dir)
      nxt_rdata = low_group_direction_ff;
    else if (hit_high_data)
      nxt_rdata = {7'h00, high_view};
    else if (hit_high_dir)
      nxt_rdata = high_pin_direction_ff & `UPR_HIGH_MASK;
    else if (hit_route)
      nxt_rdata = route_ctrl_ff[route_idx] & `UPR_ROUTE_MASK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Routing of pins 0 to 7 onto the resources

  // Select field of each routable pin, two pins per control register
  wire logic [2:0]  sel_p0     = pin_field(route_ctrl_ff[0], 1'b0); // R5
  wire logic [2:0]  sel_p1     = pin_field(route_ctrl_ff[0], 1'b1); // R5
  wire logic [2:0]  sel_p2     = pin_field(route_ctrl_ff[1], 1'b0); // R5
  wire logic [2:0]  sel_p3     = pin_field(route_ctrl_ff[1], 1'b1); // R5
  wire logic [2:0]  sel_p4     = pin_field(route_ctrl_ff[2], 1'b0); // R5
  wire logic [2:0]  sel_p5     = pin_field(route_ctrl_ff[2], 1'b1); // R5
  wire logic [2:0]  sel_p6     = pin_field(route_ctrl_ff[3], 1'b0); // R5
  wire logic [2:0]  sel_p7     = pin_field(route_ctrl_ff[3], 1'b1); // R5
  wire logic [23:0] sel_all    = {sel_p7, sel_p6, sel_p5, sel_p4,
                                  sel_p3, sel_p2, sel_p1, sel_p0};

  // Pins claimed by each resource; codes 0 and 1 claim nothing
  wire logic [7:0]  hit_t0     = sel_hits(sel_all, `UPR_SEL_TIMER0);    // R6
  wire logic [7:0]  hit_t1     = sel_hits(sel_all, `UPR_SEL_TIMER1);    // R6
  wire logic [7:0]  hit_irq0_h = sel_hits(sel_all, `UPR_SEL_IRQ0_HIGH); // R7
  wire logic [7:0]  hit_irq1_h = sel_hits(sel_all, `UPR_SEL_IRQ1_HIGH); // R7
  wire logic [7:0]  hit_irq0_l = sel_hits(sel_all, `UPR_SEL_IRQ0_LOW);  // R7
  wire logic [7:0]  hit_irq1_l = sel_hits(sel_all, `UPR_SEL_IRQ1_LOW);  // R7

  // Synchronised levels of the routable pins
  wire logic [7:0]  low_pins   = sync2_ff[7:0]; // R11

  // Claiming pins combined by OR; low-active codes see the inverted pin
  wire logic        nxt_t0       = |(hit_t0 & low_pins); // R6 R8
  wire logic        nxt_t1       = |(hit_t1 & low_pins); // R6 R8
  wire logic        nxt_irq0_lvl = (|(hit_irq0_h & low_pins))
                                 | (|(hit_irq0_l & ~low_pins)); // R7 R8
  wire logic        nxt_irq1_lvl = (|(hit_irq1_h & low_pins))
                                 | (|(hit_irq1_l & ~low_pins)); // R7 R8

  // Type bit set: one pulse per activation; clear: follow the level
  wire logic nxt_irq0_req = irq_zero_type ? (nxt_irq0_lvl & ~irq_zero_lvl_ff) : nxt_irq0_lvl; // R9
  wire logic nxt_irq1_req = irq_one_type  ? (nxt_irq1_lvl & ~irq_one_lvl_ff)  : nxt_irq1_lvl; // R9

  ////////////////////////////////////////////////////////////////////////////
  // Input synchroniser

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      sync1_ff <= `UPR_PIN_RESET;
      sync2_ff <= `UPR_PIN_RESET;
    end
    else
    begin
      sync1_ff <= user_pin_in; // R11
      sync2_ff <= sync1_ff;    // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Direction registers

  // Pin 8 keeps only its own bit, the unused bits stay at input
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      low_group_direction_ff <= `UPR_DIR_RESET; // R2
      high_pin_direction_ff  <= `UPR_DIR_RESET; // R2
    end
    else
    begin
      if (wr_low_dir)
        low_group_direction_ff <= bus_req.wdata; // R1
      if (wr_high_dir)
        high_pin_direction_ff <= (bus_req.wdata & `UPR_HIGH_MASK) | ~`UPR_HIGH_MASK; // R1
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pull-up hold

  // Any write to a group's direction register releases its pull-ups for good
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      low_pullup_ff  <= 1'b1; // R2
      high_pullup_ff <= 1'b1; // R2
    end
    else
    begin
      if (wr_low_dir)
        low_pullup_ff <= 1'b0;  // R2
      if (wr_high_dir)
        high_pullup_ff <= 1'b0; // R2
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data latches

  // Output latch of pins 0 to 7
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      low_group_data_ff <= `UPR_DATA_RESET;
    else if (wr_low_data)
      low_group_data_ff <= bus_req.wdata; // R4
  end

  // Output latch of pin 8, only bit 0 reaches the pin
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      high_pin_data_ff <= `UPR_DATA_RESET;
    else if (wr_high_data)
      high_pin_data_ff <= bus_req.wdata; // R4
  end

  ////////////////////////////////////////////////////////////////////////////
  // Route select registers

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      for (int r = 0; r < `UPR_ROUTE_COUNT; r++)
        route_ctrl_ff[r] <= `UPR_ROUTE_RESET; // R10
    end
    else if (wr_route)
      route_ctrl_ff[route_idx] <= bus_req.wdata & `UPR_ROUTE_MASK; // R10
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read answer

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      bus_rdata_ff  <= 8'h00;
      bus_rvalid_ff <= 1'b0;
    end
    else
    begin
      bus_rvalid_ff <= bus_req.rd;
      bus_rdata_ff  <= bus_req.rd ? nxt_rdata : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers

  // Pin values in pin order; direction bit 0 drives the pin
  wire logic [8:0] nxt_pin_out    = {high_pin_data_ff[0], low_group_data_ff};          // R4
  wire logic [8:0] nxt_pin_oe     = ~{high_pin_direction_ff[0], low_group_direction_ff}; // R3
  wire logic [8:0] nxt_pin_pullup = {high_pullup_ff, {8{low_pullup_ff}}};              // R2

  // Registered so every pin output comes straight from a flop
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      user_pin_out_ff    <= `UPR_PIN_RESET;
      user_pin_oe_ff     <= `UPR_OE_RESET;
      user_pin_pullup_ff <= `UPR_PIN_RESET;
    end
    else
    begin
      user_pin_out_ff    <= nxt_pin_out;
      user_pin_oe_ff     <= nxt_pin_oe;     // R3
      user_pin_pullup_ff <= nxt_pin_pullup; // R2
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Resource outputs

  // Timer inputs follow the combined pins, requests follow the type choice
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      route_out_ff <= '0;
    else
    begin
      route_out_ff.timer_zero_gate_clock <= nxt_t0;       // R6
      route_out_ff.timer_one_gate_clock  <= nxt_t1;       // R6
      route_out_ff.irq_zero_request      <= nxt_irq0_req; // R9
      route_out_ff.irq_one_request       <= nxt_irq1_req; // R9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt level history

  // Last combined level of each interrupt, for edge detection
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      irq_zero_lvl_ff <= 1'b0;
      irq_one_lvl_ff  <= 1'b0;
    end
    else
    begin
      irq_zero_lvl_ff <= nxt_irq0_lvl; // R9
      irq_one_lvl_ff  <= nxt_irq1_lvl; // R9
    end
  end

endmodule

`default_nettype wire

// [sim/upr_board.sv]
`timescale 1ns/10ps
`default_nettype none

module upr_board
(
  input  wire logic       ref_clk,
  input  wire logic [8:0] user_pin_out_ff,
  input  wire logic [8:0] user_pin_oe_ff,
  input  wire logic [8:0] user_pin_pullup_ff,
  input  wire logic [8:0] board_en,
  input  wire logic [8:0] board_val,
  output var  logic [8:0] user_pin_in
);
  logic [8:0] float_ff = 9'h0AA;

  // Floating pins wander every cycle
  always @(posedge ref_clk)
    float_ff <= ~float_ff;

  // Wire level from all drivers
  assign user_pin_in = (user_pin_oe_ff & user_pin_out_ff)
    | (~user_pin_oe_ff & board_en & board_val)
    | (~user_pin_oe_ff & ~board_en & (user_pin_pullup_ff | float_ff));
endmodule

`default_nettype wire

// [sim/upr_user_pin_port_router_sva.sv]
`timescale 1ns/10ps
`default_nettype none

module upr_chk
  import upr_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  input  wire upr_bus_req_t bus_req,
  input  wire logic [7:0]   bus_rdata_ff,
  input  wire logic         bus_rvalid_ff,
  input  wire logic [8:0]   user_pin_oe_ff,
  input  wire logic [8:0]   user_pin_pullup_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // Write to a direction register
  sequence s_dir(a);
    bus_req.wr && !bus_req.xram && bus_req.addr == a;
  endsequence

  ////////////////////////////////////////
  a_read_answered: assert property (bus_req.rd |=> bus_rvalid_ff)
    else $error("read not answered");
  a_rdata_idle: assert property (!bus_rvalid_ff |-> bus_rdata_ff == 8'h00)
    else $error("read data outside answer");
  a_low_dir_oe: assert property (s_dir(16'h0091) ##1 !bus_req.wr |=>
    user_pin_oe_ff[7:0] == ~$past(bus_req.wdata, 2))
    else $error("low group enable wrong");
  a_high_dir_oe: assert property (s_dir(16'h00A1) ##1 !bus_req.wr |=>
    user_pin_oe_ff[8] == ~$past(bus_req.wdata[0], 2))
    else $error("pin 8 enable wrong");
  a_pullup_cleared: assert property (s_dir(16'h0091) |-> ##2 user_pin_pullup_ff[7:0] == 8'h00)
    else $error("pull-up kept");
  a_pullup_held: assert property ($fell(user_pin_pullup_ff[8]) |->
    $past(bus_req.wr && !bus_req.xram && bus_req.addr == 16'h00A1, 2))
    else $error("pull-up dropped");
  a_reset_state: assert property (disable iff (1'b0) !reset_n |=>
    user_pin_oe_ff == 9'h000 && user_pin_pullup_ff == 9'h1FF)
    else $error("reset state wrong");
  a_unmapped_zero: assert property (bus_req.rd && bus_req.xram && bus_req.addr == 16'hFF94 |=>
    bus_rdata_ff == 8'h00)
    else $error("unmapped read not zero");
endmodule

`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/10ps
`default_nettype none

module tb;
  import upr_pkg::*;
  logic         ref_clk = 1'b0;
  logic         reset_n = 1'b0;
  logic         irq_zero_type = 1'b0;
  logic         irq_one_type = 1'b0;
  logic [8:0]   board_en = 9'h000;
  logic [8:0]   board_val = 9'h000;
  upr_bus_req_t bus_req = '0;
  logic [7:0]   bus_rdata_ff;
  logic         bus_rvalid_ff;
  logic [8:0]   user_pin_in, user_pin_out_ff, user_pin_oe_ff, user_pin_pullup_ff;
  upr_route_t   route_out_ff;
  int           failures = 0;
  int           check_count = 0;
  int           n, k0, k1;

  always #5 ref_clk = ~ref_clk;

  upr_user_pin_port_router u_upr_user_pin_port_router (.ref_clk, .reset_n, .bus_req,
    .bus_rdata_ff, .bus_rvalid_ff, .user_pin_in, .user_pin_out_ff, .user_pin_oe_ff,
    .user_pin_pullup_ff, .irq_zero_type, .irq_one_type, .route_out_ff);
  upr_board u_upr_board (.ref_clk, .user_pin_out_ff, .user_pin_oe_ff,
    .user_pin_pullup_ff, .board_en, .board_val, .user_pin_in);

  ////////////////////////////////////////
  task automatic check(string name, logic [8:0] seen, logic [8:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // One strobe cycle, write or read
  task automatic acc(logic x, logic [15:0] a, logic w, logic [7:0] d);
    @(negedge ref_clk);
    bus_req = '{x, a, w, !w, d};
    @(negedge ref_clk);
    bus_req = '0;
  endtask

  task automatic rd(logic x, logic [15:0] a, logic [7:0] exp);
    // Answer stands only in the cycle after the strobe
    acc(x, a, 1'b0, 8'h00);
    check("rvalid", {8'h00, bus_rvalid_ff}, 9'h001);
    check("rdata", {1'b0, bus_rdata_ff}, {1'b0, exp});
  endtask

  function automatic logic [3:0] exp_route(logic [2:0] c, logic v);
    return {c == 3'h2 && v, c == 3'h3 && v, c == 3'h4 && v || c == 3'h6 && !v,
      c == 3'h5 && v || c == 3'h7 && !v};
  endfunction

  ////////////////////////////////////////
  initial
  begin
    repeat (10) @(negedge ref_clk);
    reset_n = 1'b1;
    rd(0, 16'h0091, 8'hFF);
    rd(0, 16'h0090, 8'hFF);
    check("pullup", user_pin_pullup_ff, 9'h1FF);
    board_en = 9'h00F;
    board_val = 9'h0A5;
    acc(0, 16'h0091, 1, 8'h0F);
    acc(0, 16'h0090, 1, 8'h3C);
    rd(0, 16'h0090, 8'h35);
    check("oe", user_pin_oe_ff, 9'h0F0);
    check("pullup", user_pin_pullup_ff, 9'h100);
    check("out", user_pin_out_ff, 9'h13C);
    acc(0, 16'h00A1, 1, 8'hFE);
    acc(0, 16'h00A0, 1, 8'hFF);
    rd(0, 16'h00A1, 8'h00);
    rd(0, 16'h00A0, 8'h01);
    check("oe", user_pin_oe_ff, 9'h1F0);
    // Route selects: reset value, masked fields, unmapped neighbour
    for (n = 0; n < 4; n++)
    begin
      rd(1, 16'hFF90 + n[15:0], 8'h00);
      acc(1, 16'hFF90 + n[15:0], 1, 8'hFF);
      rd(1, 16'hFF90 + n[15:0], 8'h77);
      acc(1, 16'hFF90 + n[15:0], 1, 8'h00);
    end
    rd(1, 16'hFF94, 8'h00);
    acc(0, 16'h0091, 1, 8'hFF);
    board_en = 9'h1FF;
    // Every select code on its own pin, pin high then low
    for (n = 0; n < 16; n++)
    begin
      board_val = 9'(!n[3]) << n[2:0];
      acc(1, 16'hFF90 + n[2:1], 1, n[0] ? {1'b0, n[2:0], 4'h0} : {5'h00, n[2:0]});
      repeat (4) @(negedge ref_clk);
      check("route", {5'h00, route_out_ff}, {5'h00, exp_route(n[2:0], !n[3])});
      acc(1, 16'hFF90 + n[2:1], 1, 8'h00);
    end
    acc(1, 16'hFF90, 1, 8'h22);
    for (n = 0; n < 4; n++)
    begin
      board_val = 9'(n);
      repeat (4) @(negedge ref_clk);
      check("or", {5'h00, route_out_ff}, {5'h00, |n[1:0], 3'h0});
    end
    board_val = 9'h000;
    acc(1, 16'hFF90, 1, 8'h54);
    // Edge type gives one pulse, level type follows the pin
    for (n = 0; n < 2; n++)
    begin
      {irq_zero_type, irq_one_type} = n[0] ? 2'b00 : 2'b11;
      repeat (4) @(negedge ref_clk);
      board_val = 9'h003;
      k0 = 0;
      k1 = 0;
      repeat (8)
      begin
        @(negedge ref_clk);
        k0 += route_out_ff.irq_zero_request;
        k1 += route_out_ff.irq_one_request;
      end
      check("irq0", 9'(k0), n[0] ? 9'h006 : 9'h001);
      check("irq1", 9'(k1), n[0] ? 9'h006 : 9'h001);
      board_val = 9'h000;
    end
    summarize();
  end
endmodule

bind upr_user_pin_port_router upr_chk u_upr_chk (.ref_clk, .reset_n, .bus_req,
  .bus_rdata_ff, .bus_rvalid_ff, .user_pin_oe_ff, .user_pin_pullup_ff);

`default_nettype wire
